/* File: hdl/spc_map.svh */
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Register byte offsets: one configuration word and one status word per channel
`define SPC_CFG_BASE       8'h00
`define SPC_STAT_BASE      8'h10
`define SPC_CHAN_STRIDE    8'h04

// Configuration word field positions
`define SPC_CFG_REF_HALF   0
`define SPC_CFG_TX_DOUBLE  1
`define SPC_CFG_RX_FROM_REF 2
`define SPC_CFG_RX_FULL    3
`define SPC_CFG_DEC_BYPASS 4
`define SPC_CFG_W          5
`define SPC_CFG_RESET      5'h00

// Status word field positions
`define SPC_STAT_RXD_LSB   0
`define SPC_STAT_RXST_LSB  8
`define SPC_STAT_TXCAP_LSB 12
`define SPC_STAT_RXCLK     24
`define SPC_STAT_TXCLK     25
`define SPC_STAT_REFLVL    26

// Width of the cycle counter that measures reference half periods
`define SPC_CNT_W          8

`endif

/* File: hdl/spc_pkg.sv */
`default_nettype none

package spc_pkg;
  `include "spc_map.svh"

  // Per-channel configuration, packed in register bit order
  typedef struct packed {
    logic decBypass;
    logic rxRateFull;
    logic rxFromRef;
    logic txDouble;
    logic refHalf;
  } spc_cfg_type;

  // One received character as the deserializer and decoder deliver it
  typedef struct packed {
    logic [9:0] code;
    logic       comma;
    logic [2:0] decStatus;
    logic [7:0] decData;
  } spc_rx_char_type;

  // One captured transmit character: control over data
  typedef struct packed {
    logic [1:0] ctrl;
    logic [7:0] data;
  } spc_tx_char_type;

  // Per-channel clocking state of the top module
  typedef struct packed {
    spc_cfg_type           cfg;
    spc_tx_char_type       txCap;
    logic                  txValid;
    logic                  txClk;
    logic                  refPrev;
    logic                  recPrev;
    logic [`SPC_CNT_W-1:0] sinceEdge;
    logic [`SPC_CNT_W-1:0] lastHalf;
    logic                  rxDiv;
    logic                  rxIfClk;
    logic                  rxIfPrev;
  } spc_chan_type;
endpackage : spc_pkg

`default_nettype wire

/* File: hdl/spc_sync.sv */
`default_nettype none

module spc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         clkEn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import spc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spc_sync_state_type;

  spc_sync_state_type st;
  spc_sync_state_type next_st;

  // Elaboration-time guard against an empty synchroniser
  if (W < 1) begin : gBadW
    $error("spc_sync: width must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; the first stage feeds only the second
  always_comb begin
    next_st = st;
    if (clkEn) begin
      next_st.s1 = din;
      next_st.s2 = st.s1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.s2;
endmodule // spc_sync

`default_nettype wire

/* File: hdl/spc_rx_out.sv */
`default_nettype none

module spc_rx_out (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     clkEn,
  input  wire logic                     update,
  input  wire logic                     decBypass,
  input  wire spc_pkg::spc_rx_char_type rxChar,
  output logic                    [7:0] rxData,
  output logic                    [2:0] rxStatus
);
  import spc_pkg::*;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] status;
  } spc_rx_out_state_type;

  spc_rx_out_state_type st;
  spc_rx_out_state_type next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Output register: loads only on a presentation edge of the interface clock
  always_comb begin
    next_st = st;
    if (clkEn && update) begin
      if (decBypass) begin
        next_st.data   = rxChar.code[9:2];
        next_st.status = {rxChar.comma, rxChar.code[1:0]};
      end else begin
        next_st.data   = rxChar.decData;
        next_st.status = rxChar.decStatus;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rxData   = st.data;
  assign rxStatus = st.status;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the status meaning in both decoder settings
  bypassLowBits_a: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && update && decBypass |=> rxData == $past(rxChar.code[9:2]) && rxStatus[1:0] == $past(rxChar.code[1:0]))
    else $error("bypassed character not split across data and low status bits");
  bypassComma_a: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && update && decBypass |=> rxStatus[2] == $past(rxChar.comma))
    else $error("comma flag not shown on top status bit");
  decodedStatus_a: assert property (@(posedge clk) disable iff (!rst_b)
    clkEn && update && !decBypass |=> rxStatus == $past(rxChar.decStatus) && rxData == $past(rxChar.decData))
    else $error("decoded status or data not presented");
endmodule // spc_rx_out

`default_nettype wire

/* File: hdl/spc_top.sv */
`default_nettype none

// Behaviour
// - Half-rate reference: transmit inputs are sampled on both reference clock edges.
// - Half-rate reference as receive source: parallel outputs are presented on both reference clock edges.
// - Transmit clock out is made by the channel's transmit clock logic, synchronous.
// - Transmit clock out equals reference rate when select is 0, doubled when 1.
// - Transmit clock out holds no fixed phase to the reference clock.
// - Receive clock source select picks recovered clock or reference clock.
// - Receive interface clock is a complementary pair, full or half character rate.
// - Full rate: receive data change after the true interface clock rising edge.
// - Full rate: receive status change after the true interface clock rising edge.
// - Half rate: receive data and status change after both interface clock edges.
// - Decoder bypassed: two low status bits carry the two low code bits.
// - Decoder bypassed: top status bit is high for a comma character.
// - Decoder enabled: all three status bits carry the decoded status code.
// - Receive clock runs at one twentieth or one tenth bit rate per rate select.
module spc_top #(
  parameter int NCH = 4
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_b,
  input  wire logic                                 clkEn,
  input  wire logic                           [7:0] busAddr,
  input  wire logic                          [31:0] busWrData,
  input  wire logic                                 busWr,
  input  wire logic                                 busRd,
  output logic                               [31:0] busRdData,
  input  wire logic                       [NCH-1:0] channelReferenceClock,
  input  wire logic                       [NCH-1:0] rxRecoveredClock,
  input  wire spc_pkg::spc_rx_char_type   [NCH-1:0] rxChar,
  input  wire logic                [NCH-1:0] [7:0] transmitParallelData,
  input  wire logic                [NCH-1:0] [1:0] transmitCharacterControl,
  output logic                            [NCH-1:0] synthTransmitClockOut,
  output spc_pkg::spc_tx_char_type        [NCH-1:0] txCapturedChar,
  output logic                            [NCH-1:0] txCapturedValid,
  output logic                            [NCH-1:0] receiveInterfaceClock,
  output logic                            [NCH-1:0] receiveInterfaceClock_b,
  output logic                     [NCH-1:0] [7:0] receiveParallelData,
  output logic                     [NCH-1:0] [2:0] receiveParallelStatus
);
  import spc_pkg::*;

  typedef struct packed {
    spc_chan_type [NCH-1:0] ch;
    logic [31:0]            rdData;
  } spc_top_state_type;

  spc_top_state_type st;
  spc_top_state_type next_st;

  // Reset release
  logic [1:0]                   rstPipe;
  logic                         rstSync_b;

  // Synchronised pin levels and transmit characters
  logic [NCH-1:0]               refLvl;
  logic [NCH-1:0]               recLvl;
  spc_tx_char_type [NCH-1:0]    txPinsRaw;
  spc_tx_char_type [NCH-1:0]    txPins;

  // Edge and mode decode per channel
  logic [NCH-1:0]               refRise;
  logic [NCH-1:0]               refFall;
  logic [NCH-1:0]               selLvl;
  logic [NCH-1:0]               selRise;
  logic [NCH-1:0]               rxPass;
  logic [NCH-1:0]               rxHalf;
  logic [NCH-1:0]               rxIfRise;
  logic [NCH-1:0]               rxIfFall;
  logic [NCH-1:0]               rxUpd;

  // Receive output register contents
  logic [NCH-1:0] [2:0]         rxStatusQ;
  logic [NCH-1:0] [7:0]         rxDataQ;

  // Elaboration-time guard: the register map has room for four channels only
  if (NCH < 1 || NCH > 4) begin : gBadNch
    $error("spc_top: channel count must be 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode, shared by the write and the read path
  // Returns {hit, channel}; an offset that is not word aligned misses
  function automatic logic [2:0] decodeCh(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] off;

    off = addr - base;
    if (addr >= base && off < 8'(NCH * 4) && off[1:0] == 2'h0) begin
      decodeCh = {1'b1, off[3:2]};
    end else begin
      decodeCh = 3'h0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe[1];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; data pins take the same two stages as the clock pins,
  // so a character captured at a reference edge is the one set up for it
  spc_sync #(.W(2 * NCH)) uClkSync (
    .clk   (clk),
    .rst_b (rstSync_b),
    .clkEn (clkEn),
    .din   ({rxRecoveredClock, channelReferenceClock}),
    .dout  ({recLvl, refLvl})
  );

  // Regroup the pins per channel, so each synchronised word is {control, data}
  for (genvar c = 0; c < NCH; c++) begin : gTxPins
    assign txPinsRaw[c] = {transmitCharacterControl[c], transmitParallelData[c]};
  end

  spc_sync #(.W(10 * NCH)) uTxSync (
    .clk   (clk),
    .rst_b (rstSync_b),
    .clkEn (clkEn),
    .din   (txPinsRaw),
    .dout  (txPins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel edge and mode decode; every channel keeps its own settings
  for (genvar c = 0; c < NCH; c++) begin : gChan
    assign refRise[c]  = refLvl[c] & ~st.ch[c].refPrev;
    assign refFall[c]  = ~refLvl[c] & st.ch[c].refPrev;
    assign selLvl[c]   = st.ch[c].cfg.rxFromRef ? refLvl[c] : recLvl[c];
    assign selRise[c]  = st.ch[c].cfg.rxFromRef ? refRise[c] : (recLvl[c] & ~st.ch[c].recPrev);
    // A half-rate reference chosen as source is already the half-rate clock
    assign rxPass[c]   = st.ch[c].cfg.rxRateFull | (st.ch[c].cfg.refHalf & st.ch[c].cfg.rxFromRef);
    assign rxHalf[c]   = ~st.ch[c].cfg.rxRateFull | (st.ch[c].cfg.refHalf & st.ch[c].cfg.rxFromRef);

    // Interface clock edges, taken from the register that drives the pin
    assign rxIfRise[c] = st.ch[c].rxIfClk & ~st.ch[c].rxIfPrev;
    assign rxIfFall[c] = ~st.ch[c].rxIfClk & st.ch[c].rxIfPrev;
    // Full rate loads on the true rising edge only, half rate on both edges
    assign rxUpd[c]    = rxIfRise[c] | (rxHalf[c] & rxIfFall[c]);

    // Output register of this channel; the mode decides which edges load it
    spc_rx_out uRxOut (
      .clk       (clk),
      .rst_b     (rstSync_b),
      .clkEn     (clkEn),
      .update    (rxUpd[c]),
      .decBypass (st.ch[c].cfg.decBypass),
      .rxChar    (rxChar[c]),
      .rxData    (rxDataQ[c]),
      .rxStatus  (rxStatusQ[c])
    );

    // Output drive
    assign synthTransmitClockOut[c]   = st.ch[c].txClk;
    assign txCapturedChar[c]          = st.ch[c].txCap;
    assign txCapturedValid[c]         = st.ch[c].txValid;
    assign receiveInterfaceClock[c]   = st.ch[c].rxIfClk;
    assign receiveInterfaceClock_b[c] = ~st.ch[c].rxIfClk;
    assign receiveParallelData[c]     = rxDataQ[c];
    assign receiveParallelStatus[c]   = rxStatusQ[c];

    //////////////////////////////////////////////////////////////////////////
    // Checks on the clocking of this channel
    txHalfSample_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && st.ch[c].cfg.refHalf && refFall[c] |=> txCapturedValid[c] && txCapturedChar[c] == $past(txPins[c]))
      else $error("half-rate falling edge did not capture transmit inputs");

    txFullIgnore_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && !st.ch[c].cfg.refHalf && refFall[c] |=> !txCapturedValid[c])
      else $error("full-rate capture taken on a falling edge");

    txRateSame_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && !st.ch[c].cfg.txDouble |=> synthTransmitClockOut[c] == $past(refLvl[c]))
      else $error("transmit clock does not follow reference at rate select 0");

    txClkDouble_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && st.ch[c].cfg.txDouble && refFall[c] && st.ch[c].lastHalf >= 8'h02 |=> synthTransmitClockOut[c])
      else $error("doubled transmit clock missed its pulse on a falling reference edge");

    rxSrcSel_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && st.ch[c].cfg.rxFromRef && rxPass[c] |=> receiveInterfaceClock[c] == $past(refLvl[c]))
      else $error("receive interface clock not taken from reference");

    // Compared with the divider, since leaving pass-through need not toggle the pin
    rxDivide_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && !rxPass[c] && selRise[c] |=> receiveInterfaceClock[c] == !$past(st.ch[c].rxDiv))
      else $error("divided receive clock did not toggle on source edge");

    rxFullUpd_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      !rxHalf[c] && rxIfFall[c] |=>
        $stable(receiveParallelData[c]) && $stable(receiveParallelStatus[c]))
      else $error("full-rate receive outputs changed on a falling edge");

    rxHalfUpd_a: assert property (@(posedge clk) disable iff (!rstSync_b)
      clkEn && rxHalf[c] && (rxIfFall[c] || rxIfRise[c]) |=>
        receiveParallelData[c] == ($past(st.ch[c].cfg.decBypass) ? $past(rxChar[c].code[9:2])
                                                                  : $past(rxChar[c].decData)))
      else $error("half-rate receive outputs missed an interface edge");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for all channels and the register port
  always_comb begin
    logic [2:0]  wrSel;
    logic [2:0]  rdCfg;
    logic [2:0]  rdStat;
    logic [31:0] rdWord;
    spc_chan_type cs;

    wrSel   = 3'h0;
    rdCfg   = 3'h0;
    rdStat  = 3'h0;
    rdWord  = 32'h0000_0000;
    cs      = '0;
    next_st = st;

    // Nothing but the reset release moves while the clock enable is low, synchronisers included
    if (clkEn) begin
      for (int c = 0; c < NCH; c++) begin
        cs = st.ch[c];
        // Edge history: previous levels of both pins and of the interface clock
        cs.refPrev  = refLvl[c];
        cs.recPrev  = recLvl[c];
        cs.rxIfPrev = st.ch[c].rxIfClk;

        // Capture on the rising edge, or on both edges at half rate
        cs.txValid = refRise[c] | (st.ch[c].cfg.refHalf & refFall[c]);
        if (cs.txValid) begin
          cs.txCap = txPins[c];
        end

        // Half-period measurement for the doubled transmit clock
        // The count saturates, so a stopped reference parks the doubled clock low
        if (refRise[c] || refFall[c]) begin
          cs.lastHalf  = st.ch[c].sinceEdge + 8'h01;
          cs.sinceEdge = 8'h00;
        end else if (st.ch[c].sinceEdge != 8'hFF) begin
          cs.sinceEdge = st.ch[c].sinceEdge + 8'h01;
        end

        // Doubled clock is high for the first half of every reference half
        // period; its phase to the reference is only as good as the measure
        if (st.ch[c].cfg.txDouble) begin
          cs.txClk = cs.sinceEdge < (st.ch[c].lastHalf >> 1);
        end else begin
          cs.txClk = refLvl[c];
        end

        // Receive interface clock: pass through or divide by two
        if (selRise[c]) begin
          cs.rxDiv = ~st.ch[c].rxDiv;
        end
        cs.rxIfClk = rxPass[c] ? selLvl[c] : cs.rxDiv;
        next_st.ch[c] = cs;
      end

      // Register writes land in the next cycle; unmapped offsets are dropped
      wrSel = decodeCh(busAddr, `SPC_CFG_BASE);
      if (busWr && wrSel[2] && int'(wrSel[1:0]) < NCH) begin
        next_st.ch[wrSel[1:0]].cfg = spc_cfg_type'(busWrData[`SPC_CFG_W-1:0]);
      end

      // Register reads: data stand for the one cycle after the strobe
      // Every other cycle with the clock enable high the port reads zero; while it is low the last word holds
      rdCfg  = decodeCh(busAddr, `SPC_CFG_BASE);
      rdStat = decodeCh(busAddr, `SPC_STAT_BASE);
      if (busRd && rdCfg[2]) begin
        rdWord[`SPC_CFG_W-1:0] = st.ch[rdCfg[1:0]].cfg;
      end else if (busRd && rdStat[2]) begin
        rdWord[`SPC_STAT_RXD_LSB +: 8]    = rxDataQ[rdStat[1:0]];
        rdWord[`SPC_STAT_RXST_LSB +: 3]   = rxStatusQ[rdStat[1:0]];
        rdWord[`SPC_STAT_TXCAP_LSB +: 10] = st.ch[rdStat[1:0]].txCap;
        rdWord[`SPC_STAT_RXCLK]           = st.ch[rdStat[1:0]].rxIfClk;
        rdWord[`SPC_STAT_TXCLK]           = st.ch[rdStat[1:0]].txClk;
        rdWord[`SPC_STAT_REFLVL]          = refLvl[rdStat[1:0]];
      end
      next_st.rdData = rdWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Asserted straight from the pin, released only by the two-flop copy
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busRdData = st.rdData;
endmodule // spc_top

`default_nettype wire

/* File: tb/spc_host_model.sv */
`default_nettype none

module spc_host_model #(
  parameter int NCH = 4
) (
  input  wire logic                              clk,
  output wire logic                    [NCH-1:0] refClk,
  output wire logic                    [NCH-1:0] recClk,
  output var  spc_pkg::spc_rx_char_type [NCH-1:0] rxChar,
  output wire logic             [NCH-1:0] [7:0] txData,
  output wire logic             [NCH-1:0] [1:0] txCtrl,
  output wire spc_pkg::spc_tx_char_type [NCH-1:0] edgeChar
);
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;

  logic [7:0] cnt = 8'h00;

  // Received characters change every cycle, so a late or early load shows up
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      rxChar[c] = spc_rx_char_type'({cnt, cnt[1:0] ^ 2'(c), cnt[3] ^ cnt[0], cnt[2:0], ~cnt});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic            refQ = 1'b0;
    logic            recQ = 1'b0;
    logic [9:0]      pins = 10'(c * 77);
    spc_tx_char_type held = '0;

    // Each channel gets its own phase, so nothing may lean on alignment
    initial begin
      #(13 + c * 41); // Edges kept off both clock edges
      forever #200 refQ = ~refQ;
    end

    // Recovered clock runs continuously, unrelated to the reference
    initial begin
      #(7 + c * 61); // Edges kept off both clock edges
      forever #300 recQ = ~recQ;
    end

    // Pins move midway between reference edges, stable at both edges
    always @(refQ) begin
      held = pins;
      #100;
      pins = pins + 10'h0B3;
    end

    assign refClk[c]   = refQ;
    assign recClk[c]   = recQ;
    assign txData[c]   = pins[7:0];
    assign txCtrl[c]   = pins[9:8];
    assign edgeChar[c] = held;
  end
endmodule // spc_host_model

`default_nettype wire

/* File: tb/spc_top_tb.sv */
`default_nettype none
`include "spc_map.svh"

module spc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;

  localparam int NCH = 4;
  localparam int WIN = 240;

  logic                            clk = 1'b0;
  logic                            rst_b = 1'b0;
  logic                      [7:0] busAddr = 8'h00;
  logic                     [31:0] busWrData = 32'h0;
  logic                            busWr = 1'b0;
  logic                            busRd = 1'b0;
  logic                            clkEn = 1'b1;
  logic                     [31:0] busRdData;
  logic                  [NCH-1:0] refClk, recClk, txClkOut, txValid, ifClk, ifClkB;
  spc_rx_char_type       [NCH-1:0] rxChar;
  spc_tx_char_type       [NCH-1:0] txChar, edgeChar;
  logic           [NCH-1:0] [7:0] txData, rxData;
  logic           [NCH-1:0] [1:0] txCtrl;
  logic           [NCH-1:0] [2:0] rxStatus;
  int                              num_errors = 0;
  int                              cmp_count = 0;
  int                              cycles = 0;
  logic                            monOn = 1'b0;
  logic                      [4:0] shCfg [NCH];
  logic                  [NCH-1:0] prevIf = '0, pend = '0, have = '0, prevT = '0, prevI = '0;
  logic                      [7:0] expD [NCH];
  logic                      [2:0] expS [NCH];
  int                              nV [NCH], nT [NCH], nI [NCH];

  spc_top #(.NCH(NCH)) spc_top_inst (
    .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .channelReferenceClock(refClk),
    .rxRecoveredClock(recClk), .rxChar(rxChar), .transmitParallelData(txData),
    .transmitCharacterControl(txCtrl), .synthTransmitClockOut(txClkOut), .txCapturedChar(txChar),
    .txCapturedValid(txValid), .receiveInterfaceClock(ifClk), .receiveInterfaceClock_b(ifClkB),
    .receiveParallelData(rxData), .receiveParallelStatus(rxStatus)
  );

  spc_host_model #(.NCH(NCH)) spc_host_model_inst (
    .clk(clk), .refClk(refClk), .recClk(recClk), .rxChar(rxChar), .txData(txData),
    .txCtrl(txCtrl), .edgeChar(edgeChar)
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      finish_test();
    end
  end

  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk);
    busWr <= 1'b0;
  endtask

  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    busRd <= 1'b0;
    @(negedge clk);
    d = busRdData;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Receive output monitor: a load follows each taken interface clock edge by one cycle
  always @(negedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (monOn) begin
        if (pend[c]) begin
          check(rxData[c] === expD[c], "receive data wrong after interface edge");
          check(rxStatus[c] === expS[c], "receive status wrong after edge");
        end
        pend[c] = 1'b0;
        check(ifClkB[c] === ~ifClk[c], "interface clock pair not complementary");
        if (txValid[c] === 1'b1) check(txChar[c] === edgeChar[c], "captured character wrong");
        if (ifClk[c] !== prevIf[c]) begin
          // A falling edge in full mode must leave the outputs alone
          if (ifClk[c] || !shCfg[c][3] || (shCfg[c][0] && shCfg[c][2])) begin
            expD[c] = shCfg[c][4] ? rxChar[c].code[9:2] : rxChar[c].decData;
            expS[c] = shCfg[c][4] ? {rxChar[c].comma, rxChar[c].code[1:0]} : rxChar[c].decStatus;
            have[c] = 1'b1;
          end
          pend[c] = have[c];
        end
        nV[c] += int'(txValid[c]);
        nT[c] += int'(txClkOut[c] && !prevT[c]);
        nI[c] += int'(ifClk[c] && !prevI[c]);
      end else begin
        pend[c] = 1'b0;
        have[c] = 1'b0;
      end
      prevIf[c] = ifClk[c];
      prevT[c] = txClkOut[c];
      prevI[c] = ifClk[c];
    end
  end

  function automatic bit near(input int got, input int want);
    return got >= want - 1 && got <= want + 1;
  endfunction

  // Gives each channel its own settings, then counts clock and capture events
  task apply_cfg(input logic [4:0] c0, input logic [4:0] c1, input logic [4:0] c2, input logic [4:0] c3);
    logic [4:0] t [NCH];
    int         src;
    t = '{c0, c1, c2, c3};
    monOn = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      bus_wr(`SPC_CFG_BASE + 8'(c * 4), {27'h0, t[c]});
      shCfg[c] = t[c];
      nV[c] = 0;
      nT[c] = 0;
      nI[c] = 0;
    end
    repeat (40) @(posedge clk);
    monOn = 1'b1;
    repeat (WIN) @(posedge clk);
    monOn = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      src = t[c][2] ? WIN * 50 / 400 : WIN * 50 / 600;
      check(near(nV[c], t[c][0] ? 60 : 30), "capture count wrong");
      check(near(nT[c], t[c][1] ? 60 : 30), "transmit clock rate wrong");
      check(near(nI[c], (t[c][3] || (t[c][0] && t[c][2])) ? src : src / 2), "rx clock rate wrong");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task test_registers();
    logic [31:0] d;
    for (int c = 0; c < NCH; c++) begin
      bus_rd(`SPC_CFG_BASE + 8'(c * 4), d);
      check(d === 32'h0, "config reset value not zero");
    end
    bus_wr(8'h40, 32'hFFFFFFFF);
    bus_rd(8'h40, d);
    check(d === 32'h0, "unmapped read not zero");
    bus_wr(`SPC_CFG_BASE + 8'h04, 32'hFFFFFFFF);
    bus_rd(`SPC_CFG_BASE + 8'h04, d);
    check(d === 32'h0000001F, "config bits beyond field width");
    bus_rd(`SPC_CFG_BASE, d);
    check(d === 32'h0, "channel settings not independent");
    bus_rd(`SPC_STAT_BASE, d);
    check(d[31:27] === 5'h00, "status spare bits not zero");
  endtask

  // Full-rate reference, decoder enabled, both receive clock sources
  task test_full_rate();
    apply_cfg(5'h00, 5'h02, 5'h04, 5'h0C);
  endtask

  // Half-rate reference: both edges capture; ref-sourced rx ignores its rate select
  task test_half_rate();
    apply_cfg(5'h01, 5'h05, 5'h0D, 5'h03);
  endtask

  // Decoder bypassed: raw code bits and comma flag on the outputs
  task test_bypass();
    apply_cfg(5'h10, 5'h18, 5'h1C, 5'h1F);
  endtask

  // Clock enable low: clock, capture and receive outputs hold still
  task test_freeze();
    logic [95:0] s;
    @(posedge clk);
    clkEn <= 1'b0;
    @(negedge clk);
    s = {txClkOut, ifClk, txValid, rxData, rxStatus, txChar};
    repeat (20) @(negedge clk);
    check({txClkOut, ifClk, txValid, rxData, rxStatus, txChar} === s, "outputs moved with clock enable low");
    @(posedge clk);
    clkEn <= 1'b1;
  endtask

  initial begin
    for (int c = 0; c < NCH; c++) shCfg[c] = 5'h00;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    test_registers();
    test_full_rate();
    test_half_rate();
    test_bypass();
    test_freeze();
    finish_test();
  end
endmodule // spc_top_tb

`default_nettype wire
